// ### hdl/adapter_io_pkg.sv
// Package of address codes, field positions, widths and reset values for the adapter I/O set
package adapter_io_pkg;
  // Address lines presented with each programmed I/O transfer
  localparam int ADDR_W = 9;
  localparam int DATA_W = 26;
  // Interrupt slots: nine from outside, three from inside
  localparam int INT_EXT_N = 9;
  localparam int INT_INT_N = 3;
  localparam int INT_N     = INT_EXT_N + INT_INT_N;
  // Register widths
  localparam int RELAY_W = 15;
  localparam int DOUT_W  = 13;
  localparam int BUF_W   = 26;
  localparam int MODE_W  = 6;
  localparam int TAG_W   = 8;
  localparam int MT_W    = 5;
  localparam int FB_W    = 8;
  localparam int ERR_W   = 26;
  // Relay command word fields
  localparam int RELAY_CODE_LSB  = 0;
  localparam int RELAY_CODE_W    = 8;
  localparam int RELAY_STAGE_LSB = 8;
  localparam int RELAY_STAGE_W   = 5;
  localparam int RELAY_FIRE_BIT  = 13;
  localparam int RELAY_RESET_BIT = 14;
  // Mode/real-time field positions after a computer load
  localparam int MT_ADDR_BIT  = 0;
  localparam int MT_MODE_LSB  = 1;
  localparam int MT_MODE_W    = 3;
  localparam int MT_VALID_BIT = 4;
  // Decoded addresses
  localparam logic [ADDR_W-1:0] ADDR_INT_STORE   = 9'h001;
  localparam logic [ADDR_W-1:0] ADDR_INT_LIMIT   = 9'h002;
  localparam logic [ADDR_W-1:0] ADDR_INT_INHIBIT = 9'h003;
  localparam logic [ADDR_W-1:0] ADDR_RELAY_CMD   = 9'h010;
  localparam logic [ADDR_W-1:0] ADDR_RELAY_FB    = 9'h011;
  localparam logic [ADDR_W-1:0] ADDR_DOUT_SET    = 9'h020;
  localparam logic [ADDR_W-1:0] ADDR_DOUT_RESET  = 9'h021;
  localparam logic [ADDR_W-1:0] ADDR_TLM_BUF     = 9'h030;
  localparam logic [ADDR_W-1:0] ADDR_TLM_UNIT    = 9'h031;
  localparam logic [ADDR_W-1:0] ADDR_MODE        = 9'h032;
  localparam logic [ADDR_W-1:0] ADDR_TAG         = 9'h033;
  localparam logic [ADDR_W-1:0] ADDR_MODE_TIME   = 9'h034;
  localparam logic [ADDR_W-1:0] ADDR_ERR_LOG     = 9'h040;
  // Reset values
  localparam logic [INT_N-1:0]   RST_INHIBIT = 12'h000;
  localparam logic [RELAY_W-1:0] RST_RELAY   = 15'h0000;
  localparam logic [DOUT_W-1:0]  RST_DOUT    = 13'h0000;
  localparam logic [BUF_W-1:0]   RST_BUF     = 26'h0000000;
  localparam logic [MODE_W-1:0]  RST_MODE    = 6'h00;
  localparam logic [TAG_W-1:0]   RST_TAG     = 8'h00;
  localparam logic [MT_W-1:0]    RST_MT      = 5'h00;
  localparam logic [ERR_W-1:0]   RST_ERR     = 26'h0000000;
endpackage

// ### hdl/adapter_io_register_set.sv
// Adapter input/output register set reached by programmed I/O transfers
module adapter_io_register_set (
  input  wire logic                                REF_CLK,
  input  wire logic                                RST_N,
  input  wire logic                                PIO_STROBE,
  input  wire logic                                PIO_WRITE,
  input  wire logic [adapter_io_pkg::ADDR_W-1:0]    PIO_ADDR,
  input  wire logic [adapter_io_pkg::DATA_W-1:0]    PIO_WDATA,
  output logic      [adapter_io_pkg::DATA_W-1:0]    PIO_RDATA,
  input  wire logic [adapter_io_pkg::INT_EXT_N-1:0] EXT_INT,
  input  wire logic [adapter_io_pkg::INT_INT_N-1:0] INTERNAL_INT,
  output logic                                     INT_REQ,
  output logic [adapter_io_pkg::RELAY_CODE_W-1:0]  RELAY_CODE,
  output logic [adapter_io_pkg::RELAY_STAGE_W-1:0] STAGE_SELECT,
  output logic                                     RELAY_FIRE,
  output logic                                     RELAY_RESET,
  input  wire logic [adapter_io_pkg::FB_W-1:0]     RELAY_FEEDBACK,
  output logic      [adapter_io_pkg::DOUT_W-1:0]   DISCRETE_OUT,
  input  wire logic                                DOM_LOAD,
  input  wire logic [adapter_io_pkg::BUF_W-1:0]    DOM_DATA,
  input  wire logic [adapter_io_pkg::MT_W-1:0]     REAL_TIME,
  output logic      [adapter_io_pkg::BUF_W-1:0]    TLM_BUFFER,
  output logic      [adapter_io_pkg::MODE_W-1:0]   MODE_WORD,
  output logic      [adapter_io_pkg::TAG_W-1:0]    TAG_WORD,
  output logic      [adapter_io_pkg::MT_W-1:0]     MODE_TIME,
  output logic                                     TLM_PARITY,
  output logic                                     TLM_VALID,
  output logic                                     DATA_REQUEST,
  output logic                                     READY_BIT,
  input  wire logic                                UNIT_REPLY_INT,
  input  wire logic [adapter_io_pkg::ERR_W-1:0]    ERR_FLAGS,
  output logic      [adapter_io_pkg::ERR_W-1:0]    ERR_LOG
);
  typedef struct packed {
    logic                                int_req;
    logic [adapter_io_pkg::INT_N-1:0]    inhibit;
    logic [adapter_io_pkg::DATA_W-1:0]   rdata;
    logic [adapter_io_pkg::RELAY_W-1:0]  relay;
    logic [adapter_io_pkg::DOUT_W-1:0]   dout;
    logic [adapter_io_pkg::BUF_W-1:0]    buffer;
    logic [adapter_io_pkg::MODE_W-1:0]   mode;
    logic [adapter_io_pkg::TAG_W-1:0]    tag;
    logic [adapter_io_pkg::MT_W-1:0]     mode_time;
    logic                                parity;
    logic                                valid;
    logic                                data_req;
    logic                                ready;
    logic [adapter_io_pkg::ERR_W-1:0]    err;
  } regs_s;

  localparam regs_s RESET_STATE = '{
    int_req:   1'b0,
    inhibit:   adapter_io_pkg::RST_INHIBIT,
    rdata:     '0,
    relay:     adapter_io_pkg::RST_RELAY,
    dout:      adapter_io_pkg::RST_DOUT,
    buffer:    adapter_io_pkg::RST_BUF,
    mode:      adapter_io_pkg::RST_MODE,
    tag:       adapter_io_pkg::RST_TAG,
    mode_time: adapter_io_pkg::RST_MT,
    parity:    1'b1,
    valid:     1'b1,
    data_req:  1'b0,
    ready:     1'b0,
    err:       adapter_io_pkg::RST_ERR
  };

  regs_s state_reg;
  regs_s state_next;

  logic                             wr;
  logic                             rd;
  logic [adapter_io_pkg::INT_N-1:0] int_src;
  logic [adapter_io_pkg::INT_N-1:0] int_stored;
  logic [adapter_io_pkg::INT_N-1:0] int_ack;
  logic [adapter_io_pkg::INT_N-1:0] int_clear;
  logic                             par_buf;
  logic                             par_tag;
  logic                             par_mt;

  // Transfer qualifiers
  assign wr = PIO_STROBE && PIO_WRITE;
  assign rd = PIO_STROBE && !PIO_WRITE;

  // Twelve sources: nine from outside, three from inside
  assign int_src = {adapter_io_pkg::INT_INT_N'(INTERNAL_INT), EXT_INT};

  // Acknowledge and clear writes carry one bit per slot
  assign int_ack   = (wr && PIO_ADDR == adapter_io_pkg::ADDR_INT_LIMIT) ?
                     PIO_WDATA[adapter_io_pkg::INT_N-1:0] : '0;
  assign int_clear = (wr && PIO_ADDR == adapter_io_pkg::ADDR_INT_STORE) ?
                     PIO_WDATA[adapter_io_pkg::INT_N-1:0] : '0;

  // One storage and limiting slot per source
  generate
    for (genvar i = 0; i < adapter_io_pkg::INT_N; i++) begin : g_slot
      interrupt_slot u_slot (
        .clk    (REF_CLK),
        .rst_n  (RST_N),
        .src    (int_src[i]),
        .ack    (int_ack[i]),
        .clear  (int_clear[i]),
        .stored (int_stored[i])
      );
    end
  endgenerate

  // Subword parities over the next telemetry word, validity bit excluded
  subword_parity #(.WIDTH(adapter_io_pkg::BUF_W)) u_par_buf (
    .data   (state_next.buffer),
    .parity (par_buf)
  );
  subword_parity #(.WIDTH(adapter_io_pkg::TAG_W)) u_par_tag (
    .data   (state_next.tag),
    .parity (par_tag)
  );
  subword_parity #(.WIDTH(adapter_io_pkg::MT_W - 1)) u_par_mt (
    .data   (state_next.mode_time[adapter_io_pkg::MT_VALID_BIT-1:0]),
    .parity (par_mt)
  );

  // Register bank update and address decode
  always_comb begin
    state_next = state_reg;
    // Interrupt line from stored, unmasked slots
    state_next.int_req = |(int_stored & ~state_reg.inhibit);
    // Error log is sticky; new disagreements always record
    state_next.err = state_reg.err | ERR_FLAGS;
    // Validity drops while mode, tag or buffer is written
    state_next.valid = 1'b1;
    // Output multiplexer load fills buffer and real-time bits
    if (DOM_LOAD) begin
      state_next.buffer    = DOM_DATA;
      state_next.mode_time = REAL_TIME;
    end
    if (wr) begin
      case (PIO_ADDR)
        adapter_io_pkg::ADDR_INT_INHIBIT: begin
          state_next.inhibit = PIO_WDATA[adapter_io_pkg::INT_N-1:0];
        end
        adapter_io_pkg::ADDR_RELAY_CMD: begin
          state_next.relay = PIO_WDATA[adapter_io_pkg::RELAY_W-1:0];
        end
        adapter_io_pkg::ADDR_DOUT_SET: begin
          state_next.dout = state_reg.dout | PIO_WDATA[adapter_io_pkg::DOUT_W-1:0];
        end
        adapter_io_pkg::ADDR_DOUT_RESET: begin
          state_next.dout = state_reg.dout & ~PIO_WDATA[adapter_io_pkg::DOUT_W-1:0];
        end
        adapter_io_pkg::ADDR_TLM_BUF, adapter_io_pkg::ADDR_TLM_UNIT: begin
          state_next.buffer = PIO_WDATA[adapter_io_pkg::BUF_W-1:0];
          state_next.valid  = 1'b0;
          // Computer load: validity, three mode bits and the address bit
          state_next.mode_time[adapter_io_pkg::MT_VALID_BIT] = 1'b1;
          state_next.mode_time[adapter_io_pkg::MT_MODE_LSB +: adapter_io_pkg::MT_MODE_W] =
            state_reg.mode[adapter_io_pkg::MT_MODE_W-1:0];
          state_next.mode_time[adapter_io_pkg::MT_ADDR_BIT] = PIO_ADDR[0];
          if (PIO_ADDR == adapter_io_pkg::ADDR_TLM_UNIT) begin
            state_next.data_req = 1'b1;
            state_next.ready    = 1'b1;
          end
        end
        adapter_io_pkg::ADDR_MODE: begin
          state_next.mode  = PIO_WDATA[adapter_io_pkg::MODE_W-1:0];
          state_next.valid = 1'b0;
        end
        adapter_io_pkg::ADDR_TAG: begin
          state_next.tag   = PIO_WDATA[adapter_io_pkg::TAG_W-1:0];
          state_next.valid = 1'b0;
        end
        adapter_io_pkg::ADDR_ERR_LOG: begin
          // Written ones clear logged bits unless a new flag arrives
          state_next.err = (state_reg.err & ~PIO_WDATA[adapter_io_pkg::ERR_W-1:0]) | ERR_FLAGS;
        end
        default: begin
        end
      endcase
    end
    // Reply interrupt from the unit ends request and ready; a new load wins
    if (UNIT_REPLY_INT && !(wr && PIO_ADDR == adapter_io_pkg::ADDR_TLM_UNIT)) begin
      state_next.data_req = 1'b0;
      state_next.ready    = 1'b0;
    end
    // Read data: selected source, zero for unmapped or write-only addresses
    if (rd) begin
      case (PIO_ADDR)
        adapter_io_pkg::ADDR_INT_STORE: begin
          state_next.rdata = adapter_io_pkg::DATA_W'(int_stored);
        end
        adapter_io_pkg::ADDR_INT_INHIBIT: begin
          state_next.rdata = adapter_io_pkg::DATA_W'(state_reg.inhibit);
        end
        adapter_io_pkg::ADDR_RELAY_FB: begin
          state_next.rdata = adapter_io_pkg::DATA_W'(RELAY_FEEDBACK);
        end
        adapter_io_pkg::ADDR_DOUT_SET, adapter_io_pkg::ADDR_DOUT_RESET: begin
          state_next.rdata = adapter_io_pkg::DATA_W'(state_reg.dout);
        end
        adapter_io_pkg::ADDR_MODE_TIME: begin
          state_next.rdata = adapter_io_pkg::DATA_W'(state_reg.mode_time);
        end
        adapter_io_pkg::ADDR_ERR_LOG: begin
          state_next.rdata = state_reg.err;
        end
        default: begin
          state_next.rdata = '0;
        end
      endcase
    end
    // Odd parity: subword parities combined and inverted
    state_next.parity = ~(par_buf ^ par_tag ^ par_mt);
  end

  // Single state register
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register; relay, discrete, mode and tag words held between writes
  assign PIO_RDATA    = state_reg.rdata;
  assign INT_REQ      = state_reg.int_req;
  assign RELAY_CODE   = state_reg.relay[adapter_io_pkg::RELAY_CODE_LSB +:
                                        adapter_io_pkg::RELAY_CODE_W];
  assign STAGE_SELECT = state_reg.relay[adapter_io_pkg::RELAY_STAGE_LSB +:
                                        adapter_io_pkg::RELAY_STAGE_W];
  assign RELAY_FIRE   = state_reg.relay[adapter_io_pkg::RELAY_FIRE_BIT];
  assign RELAY_RESET  = state_reg.relay[adapter_io_pkg::RELAY_RESET_BIT];
  assign DISCRETE_OUT = state_reg.dout;
  assign TLM_BUFFER   = state_reg.buffer;
  assign MODE_WORD    = state_reg.mode;
  assign TAG_WORD     = state_reg.tag;
  assign MODE_TIME    = state_reg.mode_time;
  assign TLM_PARITY   = state_reg.parity;
  assign TLM_VALID    = state_reg.valid;
  assign DATA_REQUEST = state_reg.data_req;
  assign READY_BIT    = state_reg.ready;
  assign ERR_LOG      = state_reg.err;
endmodule

// ### hdl/interrupt_slot.sv
// One interrupt slot: storage bit plus acknowledge-limiting bit
module interrupt_slot (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic src,
  input  wire logic ack,
  input  wire logic clear,
  output logic      stored
);
  typedef struct packed {
    logic stored;
    logic limit;
  } slot_s;

  slot_s state_reg;
  slot_s state_next;

  // A source may store only while not limited; limit holds until the source drops
  always_comb begin
    state_next = state_reg;
    if (!src) begin
      state_next.limit = 1'b0;
    end
    if (ack) begin
      state_next.limit = 1'b1;
    end
    if (clear) begin
      state_next.stored = 1'b0;
    end
    if (src && !state_reg.limit) begin
      state_next.stored = 1'b1;
    end
  end

  // Slot flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign stored = state_reg.stored;
endmodule

// ### hdl/subword_parity.sv
// Even parity of one telemetry subword
module subword_parity #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] data,
  output logic                  parity
);
  // Reduction over the whole subword
  assign parity = ^data;
endmodule

// ### tb/adapter_io_register_set_bench.sv
// Self-checking bench for the adapter register set
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module adapter_io_register_set_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 1'h0, RST_N = 1'h0, PIO_STROBE = 1'h0, PIO_WRITE = 1'h0, DOM_LOAD = 1'h0;
  logic INT_REQ, RELAY_FIRE, RELAY_RESET, TLM_PARITY, TLM_VALID, DATA_REQUEST, READY_BIT;
  logic        UNIT_REPLY_INT;
  logic [8:0]  PIO_ADDR = 9'h000, EXT_INT = 9'h000;
  logic [2:0]  INTERNAL_INT = 3'h0;
  logic [25:0] PIO_WDATA = '0, DOM_DATA = '0, ERR_FLAGS = '0, PIO_RDATA, TLM_BUFFER, ERR_LOG;
  logic [7:0]  RELAY_FEEDBACK = 8'h00, RELAY_CODE, TAG_WORD;
  logic [4:0]  REAL_TIME = 5'h00, STAGE_SELECT, MODE_TIME;
  logic [12:0] DISCRETE_OUT;
  logic [5:0]  MODE_WORD;
  logic [3:0]  lag = 4'h0;
  logic [11:0] slot;
  int          n_fail = 0, total_checks = 0, cyc = 0;
  adapter_io_register_set dut_u (.*);
  unit_responder unit_u (.clk(REF_CLK), .ready(READY_BIT), .lag(lag), .reply(UNIT_REPLY_INT));
  // Clock and hang limit
  always #20 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      results();
    end
  end
  // One programmed transfer: strobe held for one rising edge
  task automatic xfer(input logic wr, input logic [8:0] a, input logic [25:0] d);
    @(negedge REF_CLK);
    PIO_STROBE = 1'h1;
    PIO_WRITE = wr;
    PIO_ADDR = a;
    PIO_WDATA = d;
    @(negedge REF_CLK);
    PIO_STROBE = 1'h0;
  endtask
  task automatic results();
    if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge REF_CLK);
    RST_N = 1'h1;
    `CHK({INT_REQ, TLM_PARITY, TLM_VALID, DISCRETE_OUT}, 16'h6000)
    // Relay word, only two stage selects, complemented feedback read back
    xfer(1'h1, adapter_io_pkg::ADDR_RELAY_CMD, 26'h00045A5);
    `CHK({RELAY_RESET, RELAY_FIRE, STAGE_SELECT, RELAY_CODE}, 15'h45A5)
    RELAY_FEEDBACK = ~RELAY_CODE;
    xfer(1'h0, adapter_io_pkg::ADDR_RELAY_FB, 26'h0);
    `CHK(PIO_RDATA[7:0], 8'h5A)
    // Discrete set and reset sides
    xfer(1'h1, adapter_io_pkg::ADDR_DOUT_SET, 26'h0001A5A);
    xfer(1'h1, adapter_io_pkg::ADDR_DOUT_SET, 26'h0000005);
    `CHK(DISCRETE_OUT, 13'h1A5F)
    xfer(1'h1, adapter_io_pkg::ADDR_DOUT_RESET, 26'h0001001);
    xfer(1'h1, adapter_io_pkg::ADDR_DOUT_RESET, 26'h0);
    xfer(1'h1, 9'h1FF, 26'h3FFFFFF);
    `CHK(DISCRETE_OUT, 13'h0A5E)
    xfer(1'h0, 9'h1FF, 26'h0);
    `CHK(PIO_RDATA, 26'h0)
    // Every slot: store, acknowledge, clear, retrigger, inhibit
    for (int i = 0; i < 12; i++) begin
      slot = 12'h001 << i;
      {INTERNAL_INT, EXT_INT} = slot;
      repeat (2) @(negedge REF_CLK);
      `CHK(INT_REQ, 1'h1)
      xfer(1'h0, adapter_io_pkg::ADDR_INT_STORE, 26'h0);
      `CHK(PIO_RDATA[11:0], slot)
      xfer(1'h1, adapter_io_pkg::ADDR_INT_LIMIT, {14'h0, slot});
      xfer(1'h1, adapter_io_pkg::ADDR_INT_STORE, {14'h0, slot});
      @(negedge REF_CLK);
      `CHK(INT_REQ, 1'h0)
      {INTERNAL_INT, EXT_INT} = 12'h000;
      @(negedge REF_CLK);
      {INTERNAL_INT, EXT_INT} = slot;
      repeat (2) @(negedge REF_CLK);
      `CHK(INT_REQ, 1'h1)
      xfer(1'h1, adapter_io_pkg::ADDR_INT_INHIBIT, {14'h0, slot | 12'hA50});
      @(negedge REF_CLK);
      `CHK(INT_REQ, 1'h0)
      xfer(1'h0, adapter_io_pkg::ADDR_INT_STORE, 26'h0);
      `CHK(PIO_RDATA[11:0], slot)
      {INTERNAL_INT, EXT_INT} = 12'h000;
      xfer(1'h1, adapter_io_pkg::ADDR_INT_STORE, {14'h0, slot});
      xfer(1'h1, adapter_io_pkg::ADDR_INT_INHIBIT, 26'h0);
      @(negedge REF_CLK);
      `CHK(INT_REQ, 1'h0)
    end
    // Mode, tag and computer buffer load
    xfer(1'h1, adapter_io_pkg::ADDR_MODE, 26'h000002D);
    `CHK({MODE_WORD, TLM_VALID}, 7'h5A)
    @(negedge REF_CLK);
    `CHK(TLM_VALID, 1'h1)
    xfer(1'h1, adapter_io_pkg::ADDR_TAG, 26'h0000096);
    xfer(1'h1, adapter_io_pkg::ADDR_TLM_BUF, 26'h2ABCDEF);
    `CHK({TAG_WORD, TLM_BUFFER, MODE_TIME}, 39'h4B_5579_BDFA)
    `CHK(TLM_PARITY, ~^{26'h2ABCDEF, 8'h96, 4'hA})
    // Output multiplexer load
    DOM_DATA = 26'h1234567;
    REAL_TIME = 5'h15;
    DOM_LOAD = 1'h1;
    @(negedge REF_CLK);
    DOM_LOAD = 1'h0;
    `CHK({TLM_BUFFER, MODE_TIME}, 31'h2468ACF5)
    // Interface unit address, answered promptly and slowly
    for (int k = 0; k < 2; k++) begin
      lag = k ? 4'h9 : 4'h0;
      xfer(1'h1, adapter_io_pkg::ADDR_TLM_UNIT, 26'h0007ABC);
      `CHK({DATA_REQUEST, READY_BIT, MODE_TIME}, 7'h7B)
      for (int w = 0; w < 40 && READY_BIT === 1'h1; w++) @(negedge REF_CLK);
      `CHK({DATA_REQUEST, READY_BIT}, 2'h0)
    end
    // Sticky error log, read and cleared by ones
    ERR_FLAGS = 26'h0000101;
    @(negedge REF_CLK);
    ERR_FLAGS = 26'h0;
    xfer(1'h0, adapter_io_pkg::ADDR_ERR_LOG, 26'h0);
    `CHK(PIO_RDATA, 26'h0000101)
    xfer(1'h1, adapter_io_pkg::ADDR_ERR_LOG, 26'h0000001);
    `CHK(ERR_LOG, 26'h0000100)
    results();
  end
endmodule

// ### tb/io_set_check_sva.sv
// Checker of transfer, latch and telemetry timing at the register set ports
module io_set_check (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        PIO_STROBE,
  input wire logic        PIO_WRITE,
  input wire logic [8:0]  PIO_ADDR,
  input wire logic [25:0] PIO_WDATA,
  input wire logic [25:0] PIO_RDATA,
  input wire logic [7:0]  RELAY_CODE,
  input wire logic [4:0]  STAGE_SELECT,
  input wire logic        RELAY_FIRE,
  input wire logic        RELAY_RESET,
  input wire logic [7:0]  RELAY_FEEDBACK,
  input wire logic [12:0] DISCRETE_OUT,
  input wire logic        DOM_LOAD,
  input wire logic [25:0] DOM_DATA,
  input wire logic [4:0]  REAL_TIME,
  input wire logic [25:0] TLM_BUFFER,
  input wire logic [5:0]  MODE_WORD,
  input wire logic [7:0]  TAG_WORD,
  input wire logic [4:0]  MODE_TIME,
  input wire logic        TLM_PARITY,
  input wire logic        TLM_VALID,
  input wire logic        DATA_REQUEST,
  input wire logic        READY_BIT,
  input wire logic        UNIT_REPLY_INT
);
  logic wr_any;
  logic dout_wr;
  logic buf_wr;
  logic tlm_wr;
  // Decoded write strobes shared by several properties
  assign wr_any  = PIO_STROBE && PIO_WRITE;
  assign dout_wr = wr_any && PIO_ADDR inside {adapter_io_pkg::ADDR_DOUT_SET,
                                              adapter_io_pkg::ADDR_DOUT_RESET};
  assign buf_wr  = wr_any && PIO_ADDR inside {adapter_io_pkg::ADDR_TLM_BUF,
                                              adapter_io_pkg::ADDR_TLM_UNIT};
  assign tlm_wr  = buf_wr || (wr_any && PIO_ADDR inside {adapter_io_pkg::ADDR_MODE,
                                                         adapter_io_pkg::ADDR_TAG});
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence wr_to(logic [8:0] a);
    wr_any && PIO_ADDR == a;
  endsequence
  sequence rd_at(logic [8:0] a);
    PIO_STROBE && !PIO_WRITE && PIO_ADDR == a;
  endsequence
  relay_load_a: assert property (
    wr_to(adapter_io_pkg::ADDR_RELAY_CMD) |=>
    {RELAY_RESET, RELAY_FIRE, STAGE_SELECT, RELAY_CODE} == $past(PIO_WDATA[14:0]))
    else $error("Relay word not loaded whole");
  dout_set_a: assert property (
    dout_wr && !PIO_ADDR[0] |=> DISCRETE_OUT == ($past(DISCRETE_OUT) | $past(PIO_WDATA[12:0])))
    else $error("Discrete set wrong");
  dout_clear_a: assert property (
    dout_wr && PIO_ADDR[0] |=> DISCRETE_OUT == ($past(DISCRETE_OUT) & ~$past(PIO_WDATA[12:0])))
    else $error("Discrete clear wrong");
  dout_hold_a: assert property (!dout_wr |=> $stable(DISCRETE_OUT))
    else $error("Discrete latch moved without write");
  feedback_read_a: assert property (
    rd_at(adapter_io_pkg::ADDR_RELAY_FB) |=> PIO_RDATA[7:0] == $past(RELAY_FEEDBACK))
    else $error("Feedback word wrong");
  parity_odd_a: assert property (
    ^{TLM_BUFFER, TAG_WORD, MODE_TIME[3:0], TLM_PARITY}) else $error("Parity not odd");
  valid_drop_a: assert property (
    tlm_wr |=> !TLM_VALID ##1 (TLM_VALID || $past(tlm_wr))) else $error("Validity wrong");
  buffer_load_a: assert property (
    wr_to(adapter_io_pkg::ADDR_TLM_BUF) |=> TLM_BUFFER == $past(PIO_WDATA) &&
    MODE_TIME == {1'h1, $past(MODE_WORD[2:0]), 1'h0}) else $error("Buffer load wrong");
  dom_load_a: assert property (
    DOM_LOAD && !buf_wr |=> TLM_BUFFER == $past(DOM_DATA) && MODE_TIME == $past(REAL_TIME))
    else $error("Multiplexer load wrong");
  unit_request_a: assert property (
    wr_to(adapter_io_pkg::ADDR_TLM_UNIT) |=> DATA_REQUEST && READY_BIT)
    else $error("Request or ready not set");
  reply_clear_a: assert property (
    UNIT_REPLY_INT && !buf_wr |=> !DATA_REQUEST && !READY_BIT)
    else $error("Request or ready not cleared");
endmodule

bind adapter_io_register_set io_set_check chk_u (.*);

// ### tb/unit_responder.sv
// Interface unit model answering the ready bit after a set lag
module unit_responder (
  input  wire logic       clk,
  input  wire logic       ready,
  input  wire logic [3:0] lag,
  output logic            reply
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  initial begin
    reply = 1'h0;
    cnt = 4'h0;
  end
  // Compare, store reply, then pulse the interrupting line once
  always @(negedge clk) begin
    if (ready && !reply && cnt == lag) begin
      reply <= 1'h1;
    end else begin
      reply <= 1'h0;
      cnt <= ready ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule
